// file: design/ddsfd_decoder.sv
// Serial frame decoder, register store and code-to-level mapping of a dual DAC
`timescale 1ns/1ps

module ddsfd_decoder
  import ddsfd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_sclk,
  input wire logic i_sync_n,
  input wire logic i_serial_data_in,
  input wire logic i_bipolar_twos,
  output logic o_sdo,
  output logic o_frame_strobe,
  output logic o_frame_error,
  output ddsfd_frame_t o_last_frame,
  output ddsfd_chan_t o_chan_a,
  output ddsfd_chan_t o_chan_b,
  output logic signed [LEVEL_BITS-1:0] o_level_a,
  output logic signed [LEVEL_BITS-1:0] o_level_b,
  output logic [15:0] o_power_word,
  output logic [15:0] o_ctrl_word
);

  // ****************************************
  // Pin synchronisers and edge finding
  // ****************************************
  logic sclk_m_reg, sclk_s_reg, sclk_d_reg;
  logic sync_m_reg, sync_s_reg, sync_d_reg;
  logic serial_data_in_m_reg, serial_data_in_s_reg, twos_m_reg, twos_s_reg;
  logic sclk_fall, sclk_rise, frame_begin, frame_end, in_frame;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      sclk_m_reg <= 1'b1;
      sclk_s_reg <= 1'b1;
      sclk_d_reg <= 1'b1;
      sync_m_reg <= 1'b1;
      sync_s_reg <= 1'b1;
      sync_d_reg <= 1'b1;
      serial_data_in_m_reg <= 1'b0;
      serial_data_in_s_reg <= 1'b0;
      twos_m_reg <= 1'b0;
      twos_s_reg <= 1'b0;
    end
    else
    begin
      sclk_m_reg <= i_sclk;
      sclk_s_reg <= sclk_m_reg;
      sclk_d_reg <= sclk_s_reg;
      sync_m_reg <= i_sync_n;
      sync_s_reg <= sync_m_reg;
      sync_d_reg <= sync_s_reg;
      serial_data_in_m_reg <= i_serial_data_in;
      serial_data_in_s_reg <= serial_data_in_m_reg;
      twos_m_reg <= i_bipolar_twos;
      twos_s_reg <= twos_m_reg;
    end
  end

  assign sclk_fall = sclk_d_reg & ~sclk_s_reg;
  assign sclk_rise = ~sclk_d_reg & sclk_s_reg;
  assign frame_begin = sync_d_reg & ~sync_s_reg;
  assign frame_end = ~sync_d_reg & sync_s_reg;
  assign in_frame = ~sync_s_reg & ~sync_d_reg;

  // ****************************************
  // Input shift register and bit counter
  // ****************************************
  logic [FRAME_BITS-1:0] shift_reg;
  logic [4:0] bit_cnt_reg;
  ddsfd_frame_t frame;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      shift_reg <= '0;
    else if (in_frame && sclk_fall)
      shift_reg <= {shift_reg[FRAME_BITS-2:0], serial_data_in_s_reg};
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst || frame_begin)
      bit_cnt_reg <= '0;
    else if (in_frame && sclk_fall && bit_cnt_reg != CNT_MAX)
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
  end

  assign frame = ddsfd_frame_t'(shift_reg);

  // ****************************************
  // Frame acceptance
  // ****************************************
  logic accept, do_write, do_read;
  logic hit_a, hit_b;

  assign accept = frame_end && (bit_cnt_reg == FRAME_BITS_CNT) && !frame.zero;
  assign do_write = accept && !frame.rw;
  assign do_read = accept && frame.rw;
  assign hit_a = (frame.chan_addr == CHAN_A) || (frame.chan_addr == CHAN_BOTH);
  assign hit_b = (frame.chan_addr == CHAN_B) || (frame.chan_addr == CHAN_BOTH);

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_frame_strobe <= 1'b0;
      o_frame_error <= 1'b0;
      o_last_frame <= '0;
    end
    else
    begin
      o_frame_strobe <= accept;
      o_frame_error <= frame_end && ((bit_cnt_reg != FRAME_BITS_CNT) || frame.zero);
      if (accept)
        o_last_frame <= frame;
    end
  end

  // ****************************************
  // Register store
  // ****************************************
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_chan_a <= '{code: CODE_RST, range_code: RANGE_UNI_5};
      o_chan_b <= '{code: CODE_RST, range_code: RANGE_UNI_5};
    end
    else if (do_write)
    begin
      case (frame.reg_sel)
        REG_DAC:
        begin
          if (hit_a)
            o_chan_a.code <= frame.data[15:SAMPLE_LSB];
          if (hit_b)
            o_chan_b.code <= frame.data[15:SAMPLE_LSB];
        end
        REG_RANGE:
        begin
          if (hit_a && frame.data[2:0] <= RANGE_LAST)
            o_chan_a.range_code <= frame.data[2:0];
          if (hit_b && frame.data[2:0] <= RANGE_LAST)
            o_chan_b.range_code <= frame.data[2:0];
        end
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_power_word <= WORD_RST;
      o_ctrl_word <= WORD_RST;
    end
    else if (do_write && frame.reg_sel == REG_POWER)
      o_power_word <= frame.data;
    else if (do_write && frame.reg_sel == REG_CTRL)
      o_ctrl_word <= frame.data;
  end

  // ****************************************
  // Readback shifter
  // ****************************************
  logic [FRAME_BITS-1:0] sdo_shift_reg;
  logic [15:0] rd_word;

  always_comb
  begin
    rd_word = WORD_RST;
    case (frame.reg_sel)
      REG_DAC:
        rd_word = (frame.chan_addr == CHAN_B) ? {o_chan_b.code, 4'h0} : {o_chan_a.code, 4'h0};
      REG_RANGE:
        rd_word = (frame.chan_addr == CHAN_B) ? {13'h0000, o_chan_b.range_code} :
                  {13'h0000, o_chan_a.range_code};
      REG_POWER:
        rd_word = o_power_word;
      REG_CTRL:
        rd_word = o_ctrl_word;
      default:
        rd_word = WORD_RST;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      sdo_shift_reg <= '0;
    else if (do_read)
      sdo_shift_reg <= {frame[FRAME_BITS-1:16], rd_word};
    else if (in_frame && sclk_rise)
      sdo_shift_reg <= {sdo_shift_reg[FRAME_BITS-2:0], 1'b0};
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_sdo <= 1'b0;
    else
      o_sdo <= sdo_shift_reg[FRAME_BITS-1];
  end

  // ****************************************
  // Code to level mapping
  // ****************************************
  function automatic logic signed [LEVEL_BITS-1:0] map_level(
    input logic [CODE_BITS-1:0] code,
    input logic [2:0] range_code,
    input logic twos
  );
    logic signed [LEVEL_BITS-1:0] lvl;
    lvl = {1'b0, code};
    if (range_code >= RANGE_BIP_FIRST)
    begin
      if (twos)
        lvl = {code[CODE_BITS-1], code};
      else
        lvl = {1'b0, code} - {1'b0, CODE_MID};
    end
    return lvl;
  endfunction

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_level_a <= '0;
      o_level_b <= '0;
    end
    else
    begin
      o_level_a <= map_level(o_chan_a.code, o_chan_a.range_code, twos_s_reg);
      o_level_b <= map_level(o_chan_b.code, o_chan_b.range_code, twos_s_reg);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_write_frame(logic [2:0] rs);
    do_write && frame.reg_sel == rs;
  endsequence

  property p_len;
    @(posedge i_clk) disable iff (i_rst)
    o_frame_strobe |-> $past(bit_cnt_reg) == FRAME_BITS_CNT;
  endproperty
  a_len: assert property (p_len) else $error("frame taken without 24 bits");

  property p_msb_first;
    @(posedge i_clk) disable iff (i_rst)
    (in_frame && sclk_fall) |=> shift_reg[0] == $past(serial_data_in_s_reg) && shift_reg[23:1] == $past(shift_reg[22:0]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("shift order wrong");

  property p_read_no_change;
    @(posedge i_clk) disable iff (i_rst)
    do_read |=> $stable(o_chan_a) && $stable(o_chan_b) && $stable(o_power_word) && $stable(o_ctrl_word);
  endproperty
  a_read_no_change: assert property (p_read_no_change) else $error("read altered a register");

  property p_reserved;
    @(posedge i_clk) disable iff (i_rst)
    (frame_end && frame.zero) |=> !o_frame_strobe && o_frame_error;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit frame accepted");

  property p_dac_a;
    @(posedge i_clk) disable iff (i_rst)
    (s_write_frame(REG_DAC) and (hit_a)) |=> o_chan_a.code == $past(frame.data[15:4]);
  endproperty
  a_dac_a: assert property (p_dac_a) else $error("channel A sample not stored");

  property p_only_b;
    @(posedge i_clk) disable iff (i_rst)
    (s_write_frame(REG_DAC) and (frame.chan_addr == CHAN_B)) |=> $stable(o_chan_a.code);
  endproperty
  a_only_b: assert property (p_only_b) else $error("channel B write touched A");

  property p_range_both;
    @(posedge i_clk) disable iff (i_rst)
    (s_write_frame(REG_RANGE) and (frame.chan_addr == CHAN_BOTH && frame.data[2:0] <= RANGE_LAST))
      |=> o_chan_a.range_code == $past(frame.data[2:0]) && o_chan_b.range_code == $past(frame.data[2:0]);
  endproperty
  a_range_both: assert property (p_range_both) else $error("range not written to both");

  property p_readback_power;
    @(posedge i_clk) disable iff (i_rst)
    (do_read && frame.reg_sel == REG_POWER)
      |=> (sdo_shift_reg[15:0] == o_power_word) ##1 (o_sdo == $past(sdo_shift_reg[FRAME_BITS-1]));
  endproperty
  a_readback_power: assert property (p_readback_power) else $error("power word not loaded for readback");

  property p_offset_mid;
    @(posedge i_clk) disable iff (i_rst)
    (o_chan_a.code == CODE_MID && o_chan_a.range_code >= RANGE_BIP_FIRST && !twos_s_reg)
      ##1 ($stable(o_chan_a) && $stable(twos_s_reg)) |=> o_level_a == 13'sh0000;
  endproperty
  a_offset_mid: assert property (p_offset_mid) else $error("offset binary midscale not zero");

  property p_twos_low;
    @(posedge i_clk) disable iff (i_rst)
    (o_chan_b.code == CODE_MID && o_chan_b.range_code >= RANGE_BIP_FIRST && twos_s_reg)
      |=> o_level_b == -13'sh0800;
  endproperty
  a_twos_low: assert property (p_twos_low) else $error("twos complement bottom wrong");

  property p_unipolar;
    @(posedge i_clk) disable iff (i_rst)
    (o_chan_b.range_code < RANGE_BIP_FIRST) |=> o_level_b == {1'b0, $past(o_chan_b.code)};
  endproperty
  a_unipolar: assert property (p_unipolar) else $error("unipolar level not straight binary");

endmodule

// file: design/ddsfd_pkg.sv
// Constants and frame layout for the serial frame decoder of a dual DAC
package ddsfd_pkg;

  // ****************************************
  // Frame geometry
  // ****************************************
  localparam int FRAME_BITS = 24;
  localparam logic [4:0] FRAME_BITS_CNT = 5'h18;
  localparam logic [4:0] CNT_MAX = 5'h1F;
  localparam int CODE_BITS = 12;
  localparam int LEVEL_BITS = 13;

  typedef struct packed {
    logic rw;              // 1 = read, 0 = write
    logic zero;            // reserved, host sends 0
    logic [2:0] reg_sel;   // reg_select_bit2..0
    logic [2:0] chan_addr; // channel_addr_bit2..0
    logic [15:0] data;
  } ddsfd_frame_t;

  // ****************************************
  // Register select and channel codes
  // ****************************************
  localparam logic [2:0] REG_DAC = 3'h0;
  localparam logic [2:0] REG_RANGE = 3'h1;
  localparam logic [2:0] REG_POWER = 3'h2;
  localparam logic [2:0] REG_CTRL = 3'h3;
  localparam logic [2:0] CHAN_A = 3'h0;
  localparam logic [2:0] CHAN_B = 3'h2;
  localparam logic [2:0] CHAN_BOTH = 3'h4;

  // ****************************************
  // Output ranges and coding
  // ****************************************
  localparam logic [2:0] RANGE_UNI_5 = 3'h0;
  localparam logic [2:0] RANGE_BIP_FIRST = 3'h3;
  localparam logic [2:0] RANGE_LAST = 3'h5;
  localparam logic [11:0] CODE_MID = 12'h800;
  localparam logic [CODE_BITS-1:0] CODE_RST = 12'h000;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam int SAMPLE_LSB = 4;

  typedef struct packed {
    logic [CODE_BITS-1:0] code;
    logic [2:0] range_code;
  } ddsfd_chan_t;

endpackage

// file: verification/ddsfd_host.sv
// Host model that drives the serial link and captures readback
`timescale 1ns/1ps
module ddsfd_host (
  input wire logic i_clk,
  input wire logic i_sdo,
  output logic o_sclk,
  output logic o_sync_n,
  output logic o_serial_data_in,
  output logic [23:0] o_rd
);
  initial
  begin
    o_sclk = 1'h1;
    o_sync_n = 1'h1;
    o_serial_data_in = 1'h0;
    o_rd = 24'h000000;
  end
  task automatic half();
    repeat (4) @(negedge i_clk);
  endtask
  // Frame of n bits, MSB first, reserved bit as given
  task automatic send(input logic [23:0] f, input int n);
    o_sync_n = 1'h0;
    for (int i = 0; i < n; i++)
    begin
      o_serial_data_in = (i < 24) ? f[23 - i] : 1'h0;
      half();
      o_sclk = 1'h0;
      half();
      o_rd = {o_rd[22:0], i_sdo};
      o_sclk = 1'h1;
    end
    half();
    o_sync_n = 1'h1;
    o_serial_data_in = ~o_serial_data_in;
    repeat (8) @(negedge i_clk);
  endtask
endmodule

// file: verification/ddsfd_decoder_test.sv
// Self-checking bench for the serial frame decoder
`timescale 1ns/1ps
module ddsfd_decoder_test
  import ddsfd_pkg::*;
;
  typedef struct {
    logic [23:0] f;
    logic [11:0] ca;
    logic [2:0] ra;
    logic [11:0] cb;
    logic [2:0] rb;
    logic [15:0] pw;
    logic [15:0] cw;
    logic [12:0] la;
    logic [12:0] lb;
  } ddsfd_row_t;
  logic i_clk, i_rst, i_bipolar_twos, sclk, sync_n, serial_data_in, sdo, stb, err;
  logic [23:0] rd;
  ddsfd_frame_t last;
  ddsfd_chan_t cha, chb;
  logic signed [LEVEL_BITS-1:0] lva, lvb;
  logic [15:0] pw, cw;
  int bad_count, checks, cycles, n_stb, n_err, s0, e0;
  ddsfd_row_t rows [11] = '{
    '{24'h00123F, 12'h123, 3'h0, 12'h000, 3'h0, 16'h0000, 16'h0000, 13'h0123, 13'h0000},
    '{24'h02ABC5, 12'h123, 3'h0, 12'hABC, 3'h0, 16'h0000, 16'h0000, 13'h0123, 13'h0ABC},
    '{24'h080003, 12'h123, 3'h3, 12'hABC, 3'h0, 16'h0000, 16'h0000, 13'h1923, 13'h0ABC},
    '{24'h0C0006, 12'h123, 3'h3, 12'hABC, 3'h0, 16'h0000, 16'h0000, 13'h1923, 13'h0ABC},
    '{24'h0C0005, 12'h123, 3'h5, 12'hABC, 3'h5, 16'h0000, 16'h0000, 13'h1923, 13'h02BC},
    '{24'h048000, 12'h800, 3'h5, 12'h800, 3'h5, 16'h0000, 16'h0000, 13'h0000, 13'h0000},
    '{24'h01FFF0, 12'h800, 3'h5, 12'h800, 3'h5, 16'h0000, 16'h0000, 13'h0000, 13'h0000},
    '{24'h100205, 12'h800, 3'h5, 12'h800, 3'h5, 16'h0205, 16'h0000, 13'h0000, 13'h0000},
    '{24'h19000A, 12'h800, 3'h5, 12'h800, 3'h5, 16'h0205, 16'h000A, 13'h0000, 13'h0000},
    '{24'h20FFFF, 12'h800, 3'h5, 12'h800, 3'h5, 16'h0205, 16'h000A, 13'h0000, 13'h0000},
    '{24'h080000, 12'h800, 3'h0, 12'h800, 3'h5, 16'h0205, 16'h000A, 13'h0800, 13'h0000}};
  logic [23:0] rdf [4] = '{24'h800000, 24'h8A0000, 24'h900000, 24'h980000};
  logic [23:0] rde [4] = '{24'h808000, 24'h8A0005, 24'h900205, 24'h98000A};
  ddsfd_decoder ddsfd_decoder_i (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_sclk(sclk),
    .i_sync_n(sync_n),
    .i_serial_data_in(serial_data_in),
    .i_bipolar_twos(i_bipolar_twos),
    .o_sdo(sdo),
    .o_frame_strobe(stb),
    .o_frame_error(err),
    .o_last_frame(last),
    .o_chan_a(cha),
    .o_chan_b(chb),
    .o_level_a(lva),
    .o_level_b(lvb),
    .o_power_word(pw),
    .o_ctrl_word(cw)
  );
  ddsfd_host ddsfd_host_i (
    .i_clk(i_clk),
    .i_sdo(sdo),
    .o_sclk(sclk),
    .o_sync_n(sync_n),
    .o_serial_data_in(serial_data_in),
    .o_rd(rd)
  );
  // ****
  // Checking and closing
  // ****
  task automatic chk(input string s, input logic [23:0] e, input logic [23:0] g);
    checks++;
    if (e !== g)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    i_clk = 1'h0;
    forever #12.5 i_clk = ~i_clk;
  end
  always @(negedge i_clk)
  begin
    cycles++;
    if (stb === 1'h1)
      n_stb++;
    if (err === 1'h1)
      n_err++;
    if (cycles == 20000)
    begin
      bad_count++;
      give_verdict();
    end
  end
  // ****
  // Main sequence
  // ****
  initial
  begin
    i_rst = 1'h1;
    i_bipolar_twos = 1'h0;
    repeat (2) @(negedge i_clk);
    i_rst = 1'h0;
    repeat (3) @(negedge i_clk);
    chk("reset_chan_a", 24'h0, cha);
    chk("reset_level_b", 24'h0, {lvb});
    foreach (rows[k])
    begin
      ddsfd_host_i.send(rows[k].f, 24);
      chk("code_a", rows[k].ca, cha.code);
      chk("code_b", rows[k].cb, chb.code);
      chk("range_a", rows[k].ra, cha.range_code);
      chk("range_b", rows[k].rb, chb.range_code);
      chk("power", rows[k].pw, pw);
      chk("ctrl", rows[k].cw, cw);
      chk("level_a", rows[k].la, {lva});
      chk("level_b", rows[k].lb, {lvb});
    end
    i_bipolar_twos = 1'h1;
    ddsfd_host_i.send(24'h027FF0, 24);
    chk("twos_top", 24'h0007FF, {lvb});
    ddsfd_host_i.send(24'h028000, 24);
    chk("twos_bottom", 24'h001800, {lvb});
    foreach (rdf[k])
    begin
      ddsfd_host_i.send(rdf[k], 24);
      ddsfd_host_i.send(24'hA00000, 24);
      chk("readback", rde[k], rd);
    end
    e0 = n_err;
    s0 = n_stb;
    ddsfd_host_i.send(24'h00FFF0, 23);
    ddsfd_host_i.send(24'h00FFF0, 25);
    ddsfd_host_i.send(24'h40FFF0, 24);
    chk("code_kept", 24'h800, cha.code);
    ddsfd_host_i.send(24'h00FFF0, 24);
    chk("errors", 24'h3, n_err - e0);
    chk("strobes", 24'h1, n_stb - s0);
    chk("code_new", 24'hFFF, cha.code);
    chk("last_frame", 24'h00FFF0, last);
    i_rst = 1'h1;
    repeat (2) @(negedge i_clk);
    i_rst = 1'h0;
    repeat (3) @(negedge i_clk);
    chk("rerun_code", 24'h0, cha.code);
    chk("rerun_power", 24'h0, pw);
    chk("rerun_last", 24'h0, last);
    give_verdict();
  end
endmodule
